// *** hdl/rscl_top.sv ***
/*
 Reset strap configuration latch: captures the strap port during reset, decodes it,
 guards the initialization phase and offers the settings over classic Wishbone.
 Assumes one 250 MHz clock, synchronous active-high reset and board pull-downs or open pins.
*/
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "rscl_map.svh"

module rscl_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] strap_port_i,
    input wire logic end_of_init_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [23:0] fetch_addr_o,
    output logic fetch_start_o,
    output logic init_active_o,
    output logic [3:0] clk_mult_x2_o,
    output logic [7:0] addr_line_en_o,
    output logic [4:0] cs_en_o,
    output logic single_wr_strobe_o,
    output logic [1:0] boot_bus_type_o,
    output logic bsl_active_o,
    output logic adapter_active_o,
    output logic emu_active_o,
    output logic [31:0] cs_timing_o
);

    logic [15:0] strap_level;
    logic [15:0] startup_strap_word_r;
    logic [15:0] startup_strap_word_nxt;
    logic [15:0] active_cfg_r;
    logic [15:0] active_cfg_nxt;
    logic [31:0] cs_timing_r;
    logic [31:0] cs_timing_nxt;
    rscl_pkg::rscl_phase_t phase_r;
    rscl_pkg::rscl_phase_t phase_nxt;
    rscl_pkg::rscl_cfg_t cfg_dec;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic fetch_start_r;
    logic rsv_bad_r;

    rscl_strap_sync #(
        .W(16)
    ) u_sync (
        .clk_i(clk_i),
        .pin_i(strap_port_i),
        .level_o(strap_level)
    );

    rscl_decode u_dec (
        .word_i(active_cfg_r),
        .cfg_o(cfg_dec)
    );

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i;
    wire hit_strap = (wb_adr_i == `RSCL_OFS_STRAP);
    wire hit_active = (wb_adr_i == `RSCL_OFS_ACTIVE);
    wire hit_status = (wb_adr_i == `RSCL_OFS_STATUS);
    wire hit_ctrl = (wb_adr_i == `RSCL_OFS_CTRL);
    wire hit_cstime = (wb_adr_i == `RSCL_OFS_CSTIME);
    // Writes land on the edge where the master sees ack, not earlier
    wire wr_fire = req & wb_we_i & ack_r;
    wire in_init = (phase_r == rscl_pkg::RSCL_PH_INIT);
    wire ctrl_end_of_init_instruction = wr_fire & hit_ctrl & wb_sel_i[0] & wb_dat_i[`RSCL_CTRL_END_OF_INIT_INSTRUCTION_BIT];
    wire end_of_init_instruction_evt = end_of_init_i | ctrl_end_of_init_instruction;
    wire wr_active = wr_fire & hit_active & in_init;
    wire wr_cstime = wr_fire & hit_cstime;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = nv[i*8 +: 8];
            end
        end
        return res;
    endfunction

    wire [31:0] active_merged = merge({16'h0000, active_cfg_r}, wb_dat_i, wb_sel_i);
    wire [31:0] status_word = {
        24'h000000,
        rsv_bad_r,
        (phase_r == rscl_pkg::RSCL_PH_RUN),
        cfg_dec.emu_active,
        cfg_dec.adapter_active,
        cfg_dec.bsl_active,
        cfg_dec.single_wr_strobe,
        1'b0,
        in_init
    };

    // Reset phase captures, init allows reconfiguration, run locks the active configuration while CS timing stays writable
    always_comb
    begin
        phase_nxt = phase_r;
        case (phase_r)
            rscl_pkg::RSCL_PH_RESET:
            begin
                phase_nxt = rscl_pkg::RSCL_PH_INIT;
            end
            rscl_pkg::RSCL_PH_INIT:
            begin
                if (end_of_init_instruction_evt)
                begin
                    phase_nxt = rscl_pkg::RSCL_PH_RUN;
                end
            end
            rscl_pkg::RSCL_PH_RUN:
            begin
                phase_nxt = rscl_pkg::RSCL_PH_RUN;
            end
            default:
            begin
                phase_nxt = rscl_pkg::RSCL_PH_RESET;
            end
        endcase
    end

    // Sampling runs only while reset is held; later pin traffic is ignored
    always_comb
    begin
        startup_strap_word_nxt = startup_strap_word_r;
        if (rst_i)
        begin
            startup_strap_word_nxt = strap_level;
        end
    end

    always_comb
    begin
        active_cfg_nxt = active_cfg_r;
        if (phase_r == rscl_pkg::RSCL_PH_RESET)
        begin
            active_cfg_nxt = startup_strap_word_r;
        end
        else if (wr_active)
        begin
            active_cfg_nxt = active_merged[15:0];
        end
    end

    assign cs_timing_nxt = wr_cstime ? merge(cs_timing_r, wb_dat_i, wb_sel_i) : cs_timing_r;

    always_comb
    begin
        rdata_nxt = 32'h00000000;
        if (hit_strap)
        begin
            rdata_nxt = {16'h0000, startup_strap_word_r};
        end
        else if (hit_active)
        begin
            rdata_nxt = {16'h0000, active_cfg_r};
        end
        else if (hit_status)
        begin
            rdata_nxt = status_word;
        end
        else if (hit_cstime)
        begin
            rdata_nxt = cs_timing_r;
        end
    end

    // Strap latch has no reset so the pins are seen while rst_i is high
    always_ff @(posedge clk_i)
    begin
        startup_strap_word_r <= startup_strap_word_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_r <= rscl_pkg::RSCL_PH_RESET;
            active_cfg_r <= `RSCL_STRAP_RST;
            cs_timing_r <= `RSCL_CSTIME_RST;
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
            fetch_start_r <= 1'b0;
            rsv_bad_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            active_cfg_r <= active_cfg_nxt;
            cs_timing_r <= cs_timing_nxt;
            ack_r <= req & ~ack_r;
            rdata_r <= rdata_nxt;
            fetch_start_r <= (phase_r == rscl_pkg::RSCL_PH_RESET);
            // Reserved straps not high mean a mis-strapped board
            rsv_bad_r <= ((startup_strap_word_r & `RSCL_RSV_MASK) != `RSCL_RSV_MASK);
        end
    end

    // Outputs are registered from the decoded active configuration, the phase, the CS timing and the fixed fetch address
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fetch_addr_o <= `RSCL_START_ADDR;
            init_active_o <= 1'b0;
            clk_mult_x2_o <= 4'h6;
            addr_line_en_o <= 8'h03;
            cs_en_o <= 5'h1F;
            single_wr_strobe_o <= 1'b1;
            boot_bus_type_o <= 2'h3;
            bsl_active_o <= 1'b0;
            adapter_active_o <= 1'b0;
            emu_active_o <= 1'b0;
            cs_timing_o <= `RSCL_CSTIME_RST;
        end
        else
        begin
            fetch_addr_o <= `RSCL_START_ADDR;
            init_active_o <= in_init;
            clk_mult_x2_o <= cfg_dec.clk_mult_x2;
            addr_line_en_o <= cfg_dec.addr_line_en;
            cs_en_o <= cfg_dec.cs_en;
            single_wr_strobe_o <= cfg_dec.single_wr_strobe;
            boot_bus_type_o <= cfg_dec.bus_type;
            bsl_active_o <= cfg_dec.bsl_active;
            adapter_active_o <= cfg_dec.adapter_active;
            emu_active_o <= cfg_dec.emu_active;
            cs_timing_o <= cs_timing_r;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign fetch_start_o = fetch_start_r;

endmodule // rscl_top

// *** hdl/rscl_map.svh ***
/*
 Register offsets, strap field positions, reset values and fixed addresses of the strap latch.
 Assumes a 32-bit classic Wishbone slave with byte addresses.
*/
`ifndef RSCL_MAP_SVH
`define RSCL_MAP_SVH

`define RSCL_OFS_STRAP 8'h00
`define RSCL_OFS_ACTIVE 8'h04
`define RSCL_OFS_STATUS 8'h08
`define RSCL_OFS_CTRL 8'h0C
`define RSCL_OFS_CSTIME 8'h10

`define RSCL_STRAP_W 16
`define RSCL_STRAP_RST 16'hFFFF
`define RSCL_RSV_MASK 16'h002C
`define RSCL_CLK_HI 15
`define RSCL_CLK_LO 13
`define RSCL_SAL_HI 12
`define RSCL_SAL_LO 11
`define RSCL_CS_HI 10
`define RSCL_CS_LO 9
`define RSCL_WRC_BIT 8
`define RSCL_BUS_HI 7
`define RSCL_BUS_LO 6
`define RSCL_BSL_BIT 4
`define RSCL_ADP_BIT 1
`define RSCL_EMU_BIT 0

`define RSCL_CTRL_END_OF_INIT_INSTRUCTION_BIT 0
`define RSCL_CSTIME_RST 32'h00000000
`define RSCL_START_ADDR 24'h000000

`endif

// *** hdl/rscl_pkg.sv ***
/*
 Types of the strap latch: run phases and the decoded configuration carrier.
 Assumes rscl_map.svh supplies all numeric constants.
*/
package rscl_pkg;

    typedef enum logic [1:0] {
        RSCL_PH_RESET = 2'b00,
        RSCL_PH_INIT = 2'b01,
        RSCL_PH_RUN = 2'b10
    } rscl_phase_t;

    typedef enum logic [1:0] {
        RSCL_BUS_8_DEMUX = 2'b00,
        RSCL_BUS_8_MUX = 2'b01,
        RSCL_BUS_16_DEMUX = 2'b10,
        RSCL_BUS_16_MUX = 2'b11
    } rscl_bus_t;

    typedef struct packed {
        logic [3:0] clk_mult_x2;
        logic [7:0] addr_line_en;
        logic [4:0] cs_en;
        logic single_wr_strobe;
        rscl_bus_t bus_type;
        logic bsl_active;
        logic adapter_active;
        logic emu_active;
    } rscl_cfg_t;

endpackage

// *** hdl/rscl_strap_sync.sv ***
/*
 Three-flop synchroniser for the strap pins with agreement filter.
 Assumes pins are asynchronous to clk_i; open pins already read high.
 No reset: the stages must keep tracking the pins while reset is held, or the capture would only see the preset.
*/
`timescale 1ns/10ps
`include "rscl_map.svh"

module rscl_strap_sync #(
    parameter int W = `RSCL_STRAP_W
) (
    input wire logic clk_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] agree;

    // A bit only moves once the second and third stages agree
    assign agree = ~(s2_r ^ s3_r);

    // Free running so the pins are seen during reset; settles within four edges
    always_ff @(posedge clk_i)
    begin
        s1_r <= pin_i;
        s2_r <= s1_r;
        s3_r <= s2_r;
        level_o <= (agree & s3_r) | (~agree & level_o);
    end

endmodule // rscl_strap_sync

// *** hdl/rscl_decode.sv ***
/*
 Decodes a strap-format configuration word into system settings.
 Purely combinational; the caller registers the result.
*/
`timescale 1ns/10ps
`include "rscl_map.svh"

module rscl_decode (
    input wire logic [15:0] word_i,
    output rscl_pkg::rscl_cfg_t cfg_o
);

    function automatic logic [3:0] clk_mult(input logic [2:0] code);
        case (code)
            3'h0: clk_mult = 4'h1;
            3'h1: clk_mult = 4'h5;
            3'h2: clk_mult = 4'h5;
            3'h3: clk_mult = 4'h2;
            3'h4: clk_mult = 4'hA;
            3'h5: clk_mult = 4'h4;
            3'h6: clk_mult = 4'h9;
            default: clk_mult = 4'h6;
        endcase
    endfunction

    function automatic logic [7:0] addr_lines(input logic [1:0] code);
        case (code)
            2'h0: addr_lines = 8'h0F;
            2'h1: addr_lines = 8'h00;
            2'h2: addr_lines = 8'hFF;
            default: addr_lines = 8'h03;
        endcase
    endfunction

    function automatic logic [4:0] cs_lines(input logic [1:0] code);
        case (code)
            2'h0: cs_lines = 5'h07;
            2'h1: cs_lines = 5'h03;
            2'h2: cs_lines = 5'h00;
            default: cs_lines = 5'h1F;
        endcase
    endfunction

    // Multiplier is given times two so the half steps stay integral
    assign cfg_o.clk_mult_x2 = clk_mult(word_i[`RSCL_CLK_HI:`RSCL_CLK_LO]);
    assign cfg_o.addr_line_en = addr_lines(word_i[`RSCL_SAL_HI:`RSCL_SAL_LO]);
    assign cfg_o.cs_en = cs_lines(word_i[`RSCL_CS_HI:`RSCL_CS_LO]);
    assign cfg_o.single_wr_strobe = word_i[`RSCL_WRC_BIT];
    assign cfg_o.bus_type = rscl_pkg::rscl_bus_t'(word_i[`RSCL_BUS_HI:`RSCL_BUS_LO]);
    assign cfg_o.bsl_active = ~word_i[`RSCL_BSL_BIT];
    assign cfg_o.adapter_active = ~word_i[`RSCL_ADP_BIT];
    assign cfg_o.emu_active = ~word_i[`RSCL_EMU_BIT];

endmodule // rscl_decode

// *** verif/rscl_board_model.sv ***
/*
 Board side of the strap port: pull-down resistors or open pins.
 Assumes a set bit of pull_dn_i marks a fitted pull-down.
*/
`timescale 1ns/10ps
`include "rscl_map.svh"

module rscl_board_model (
    input wire logic [15:0] pull_dn_i,
    output logic [15:0] strap_port_o
);
    // Reserved positions never get a pull-down, whatever the bench asks
    assign strap_port_o = ~(pull_dn_i & ~`RSCL_RSV_MASK);
endmodule // rscl_board_model

// *** verif/rscl_top_sva.sv ***
/*
 Checker for the strap latch outputs.
 Assumes one clock and the synchronous active-high reset of the top module.
*/
`timescale 1ns/10ps

module rscl_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic end_of_init_i,
    input wire logic [23:0] fetch_addr_o,
    input wire logic fetch_start_o,
    input wire logic init_active_o,
    input wire logic [3:0] clk_mult_x2_o,
    input wire logic [7:0] addr_line_en_o,
    input wire logic [4:0] cs_en_o
);
    logic run_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Run phase seen once init has dropped; cleared only by reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            run_r <= 1'b0;
        else if ($fell(init_active_o))
            run_r <= 1'b1;
    end
    chk_fetch_zero:
        assert property (fetch_addr_o == 24'h000000) else $error("fetch address not zero");
    chk_start_after:
        assert property ($fell(rst_i) |-> ##[1:3] fetch_start_o) else $error("no fetch start after reset");
    chk_start_single:
        assert property (fetch_start_o |=> !fetch_start_o) else $error("fetch start longer than one cycle");
    chk_eoi_answer:
        assert property (end_of_init_i && init_active_o |-> ##[1:3] !init_active_o) else $error("init not ended");
    chk_init_stays:
        assert property (run_r |-> !init_active_o) else $error("init phase came back");
    chk_cfg_frozen:
        assert property (run_r |=> $stable({clk_mult_x2_o, addr_line_en_o, cs_en_o})) else $error("config moved");
    chk_clk_code:
        assert property (clk_mult_x2_o inside {4'h1, 4'h5, 4'h2, 4'hA, 4'h4, 4'h9, 4'h6}) else $error("bad mult");
    chk_addr_code:
        assert property (addr_line_en_o inside {8'h0F, 8'h00, 8'hFF, 8'h03}) else $error("bad address lines");
    chk_cs_code:
        assert property (cs_en_o inside {5'h07, 5'h03, 5'h00, 5'h1F}) else $error("bad chip selects");
endmodule // rscl_chk

bind rscl_top rscl_chk chk_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .end_of_init_i(end_of_init_i),
    .fetch_addr_o(fetch_addr_o),
    .fetch_start_o(fetch_start_o),
    .init_active_o(init_active_o),
    .clk_mult_x2_o(clk_mult_x2_o),
    .addr_line_en_o(addr_line_en_o),
    .cs_en_o(cs_en_o)
);

// *** verif/testbench.sv ***
/*
 Self-checking bench: random straps per reset, register traffic, end of init.
 Assumes the 250 MHz clock; the master waits for the Wishbone ack of each request.
*/
`timescale 1ns/10ps
`include "rscl_map.svh"

module testbench;
    logic clk_i, rst_i, end_of_init_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, cs_timing_o;
    logic wb_ack_o, fetch_start_o, init_active_o, single_wr_strobe_o;
    logic bsl_active_o, adapter_active_o, emu_active_o;
    logic [23:0] fetch_addr_o;
    logic [3:0] clk_mult_x2_o;
    logic [7:0] addr_line_en_o;
    logic [4:0] cs_en_o;
    logic [1:0] boot_bus_type_o;
    logic [15:0] pull_dn, strap, w, a;
    logic [31:0] d, cfg_seen, q[$];
    integer seed = 77;
    int fails = 0, samples_checked = 0, cycles = 0;

    assign cfg_seen = {9'h000, clk_mult_x2_o, addr_line_en_o, cs_en_o, single_wr_strobe_o,
        boot_bus_type_o, bsl_active_o, adapter_active_o, emu_active_o};

    rscl_board_model board_u (.pull_dn_i(pull_dn), .strap_port_o(strap));
    rscl_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .strap_port_i(strap), .end_of_init_i(end_of_init_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .fetch_addr_o(fetch_addr_o), .fetch_start_o(fetch_start_o), .init_active_o(init_active_o),
        .clk_mult_x2_o(clk_mult_x2_o), .addr_line_en_o(addr_line_en_o), .cs_en_o(cs_en_o),
        .single_wr_strobe_o(single_wr_strobe_o), .boot_bus_type_o(boot_bus_type_o),
        .bsl_active_o(bsl_active_o), .adapter_active_o(adapter_active_o),
        .emu_active_o(emu_active_o), .cs_timing_o(cs_timing_o));

    always #2 clk_i = ~clk_i;

    function automatic logic [31:0] exp_cfg(input logic [15:0] v);
        logic [3:0] mt [8] = '{4'h1, 4'h5, 4'h5, 4'h2, 4'hA, 4'h4, 4'h9, 4'h6};
        logic [7:0] at [4] = '{8'h0F, 8'h00, 8'hFF, 8'h03};
        logic [4:0] ct [4] = '{5'h07, 5'h03, 5'h00, 5'h1F};
        return {9'h000, mt[v[15:13]], at[v[12:11]], ct[v[10:9]], v[8], v[7:6], ~v[4], ~v[1], ~v[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // The master never assumes the one-cycle answer; it waits for ack
    task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= ad;
        wb_dat_i <= dt;
        wb_sel_i <= 4'hF;
        do
        begin
            @(posedge clk_i);
        end
        while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, ad, 32'h00000000);
    endtask

    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i && q.size() > 0)
            check("rdata", wb_dat_o, q.pop_front());
    end

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        end_of_init_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
        pull_dn = 16'h0000;
        for (int i = 0; i < 8; i++)
        begin
            w = {i[2:0], 13'($random(seed))} | `RSCL_RSV_MASK;
            @(posedge clk_i);
            rst_i <= 1'b1;
            pull_dn <= ~w;
            repeat (16) @(posedge clk_i);
            rst_i <= 1'b0;
            repeat (5) @(posedge clk_i);
            pull_dn <= 16'($random(seed));
            check("cfg", cfg_seen, exp_cfg(w));
            check("init", {31'h00000000, init_active_o}, 32'h00000001);
            rd(`RSCL_OFS_STRAP, {16'h0000, w});
            rd(`RSCL_OFS_ACTIVE, {16'h0000, w});
            a = 16'($random(seed)) | `RSCL_RSV_MASK;
            bus(1'b1, `RSCL_OFS_ACTIVE, {16'h0000, a});
            rd(`RSCL_OFS_ACTIVE, {16'h0000, a});
            rd(`RSCL_OFS_STATUS, {24'h000000, 2'b00, ~a[0], ~a[1], ~a[4], a[8], 1'b0, 1'b1});
            repeat (3) @(posedge clk_i);
            check("cfg", cfg_seen, exp_cfg(a));
            d = $random(seed);
            bus(1'b1, `RSCL_OFS_CSTIME, d);
            rd(`RSCL_OFS_CSTIME, d);
            check("cstime", cs_timing_o, d);
            rd(8'h20, 32'h00000000);
            if (i[0])
            begin
                @(posedge clk_i);
                end_of_init_i <= 1'b1;
                @(posedge clk_i);
                end_of_init_i <= 1'b0;
            end
            else
                bus(1'b1, `RSCL_OFS_CTRL, 32'h00000001);
            repeat (4) @(posedge clk_i);
            check("init", {31'h00000000, init_active_o}, 32'h00000000);
            bus(1'b1, `RSCL_OFS_ACTIVE, {16'h0000, ~a});
            rd(`RSCL_OFS_ACTIVE, {16'h0000, a});
            rd(`RSCL_OFS_STRAP, {16'h0000, w});
            repeat (3) @(posedge clk_i);
            check("cfg", cfg_seen, exp_cfg(a));
        end
        stop_test();
    end
endmodule // testbench
